// [hw/wdg_map.vh]
// register map, field positions, reset values and timing counts
`ifndef WDG_MAP_VH
`define WDG_MAP_VH

// register byte offsets, one aligned word each
`define WDG_CTRL_A      8'h00
`define WDG_TIMEOUT_A   8'h04
`define WDG_WINDOW_A    8'h08
`define WDG_KICK_A      8'h0c
`define WDG_CTRL_B      8'h10
`define WDG_TIMEOUT_B   8'h14
`define WDG_WINDOW_B    8'h18
`define WDG_KICK_B      8'h1c
`define WDG_CTRL_R      8'h20
`define WDG_TIMEOUT_R   8'h24
`define WDG_KICK_R      8'h28
`define WDG_CAUSE       8'h2c
`define WDG_COUNT_A     8'h30
`define WDG_COUNT_B     8'h34
`define WDG_COUNT_R     8'h38

// control field positions
`define WDG_EN_BIT      0
`define WDG_WIN_BIT     1
`define WDG_SEL_LSB     2
`define WDG_SEL_MSB     3
`define WDG_PRE_LSB     8
`define WDG_PRE_MSB     15

// count clock choices for the main watchdogs
`define WDG_SEL_SYS     2'h0
`define WDG_SEL_RTC     2'h1
`define WDG_SEL_PM      2'h2

// cause flag positions
`define WDG_CAUSE_A     0
`define WDG_CAUSE_B     1
`define WDG_CAUSE_R     2

// reset values and service key
`define WDG_CTRL_RST    16'h0000
`define WDG_TMO_RST     32'h0000ffff
`define WDG_WIN_RST     32'h00000000
`define WDG_TMO_R_RST   16'hffff
`define WDG_KICK_KEY    8'ha5

// timing: reference clock and system reset pulse
`define WDG_CLK_MHZ     10
`define WDG_RST_NS      1000
`define WDG_RST_CYC     ((`WDG_RST_NS * `WDG_CLK_MHZ + 999) / 1000)
`define WDG_SYS_DIV     16

`endif

// [hw/wdg_counter.v]
// one watchdog: prescaler, up counter, window and timeout compare
`timescale 1ns/1ps
`default_nettype none

module wdg_counter #(
    parameter WIDTH = 32
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             run,
    input  wire             tick,
    input  wire             kick,
    input  wire             win_en,
    input  wire [7:0]       presc,
    input  wire [WIDTH-1:0] timeout,
    input  wire [WIDTH-1:0] win_open,
    output reg  [WIDTH-1:0] count,
    output reg              expire
);

    reg  [7:0] pre_cnt;
    wire       step;
    wire       early;

    // one counter step every presc+1 count-clock ticks
    assign step  = run & tick & (pre_cnt == presc);
    // a service before the window opens counts as a violation
    assign early = run & kick & win_en & (count < win_open);

    ////////////////////////////////////////////////////////////////////////
    // prescaler and counter
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_cnt <= 8'h00;
            count   <= {WIDTH{1'b0}};
            expire  <= 1'b0;
        end
        else
        begin
            // expiry: missed deadline or early service
            expire <= early | (step & (count == timeout));
            if (!run)
            begin
                pre_cnt <= 8'h00;
                count   <= {WIDTH{1'b0}};
            end
            else if (kick)
            begin
                // service restarts the whole period
                pre_cnt <= 8'h00;
                count   <= {WIDTH{1'b0}};
            end
            else if (tick)
            begin
                pre_cnt <= (pre_cnt == presc) ? 8'h00 : pre_cnt + 8'h01;
                if (step)
                    count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // wdg_counter

`default_nettype wire

// [hw/wdg_top.v]
// watchdog subsystem: two windowed main watchdogs and one recovery watchdog
//
// Functional notes
// - two independent prescaled 32-bit main watchdogs, expiry resets
// - no service in the programmed window: timeout and watchdog reset
// - main watchdog expiry sets its own cause flag, visible after reset
// - main count clock: scaled system clock, real-time or power clock
// - third recovery watchdog, 16-bit counter, expiry asserts system reset
// - recovery watchdog expiry sets its own cause flag
// - recovery watchdog counts only on the 8 kHz ring oscillator
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_map.vh"

module wdg_top (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    input  wire        rtc_clk,
    input  wire        pm_clk,
    input  wire        ring_clk,
    output reg         sys_reset,
    output reg  [2:0]  reset_cause
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    reg  [2:0]  pin_s1;
    reg  [2:0]  pin_s2;
    reg  [2:0]  pin_s3;
    reg  [2:0]  pin_lvl;
    reg  [2:0]  pin_rise;
    wire [2:0]  pin_chg;
    reg  [4:0]  sys_div;
    reg         sys_tick;
    reg  [15:0] ctrl_a;
    reg  [15:0] ctrl_b;
    reg         ctrl_r;
    reg  [31:0] tmo_a;
    reg  [31:0] tmo_b;
    reg  [31:0] win_a;
    reg  [31:0] win_b;
    reg  [15:0] tmo_r;
    reg         kick_a;
    reg         kick_b;
    reg         kick_r;
    reg  [3:0]  rst_cnt;
    wire [31:0] count_a;
    wire [31:0] count_b;
    wire [15:0] count_r;
    wire        exp_a;
    wire        exp_b;
    wire        exp_r;
    wire        any_exp;
    wire        key_ok;
    wire        bus_wr;
    reg         tick_a;
    reg         tick_b;

    // divider and pulse counts as wide constants, cut to width on purpose
    localparam [31:0] SYS_LAST = `WDG_SYS_DIV - 1;
    localparam [31:0] RST_LOAD = `WDG_RST_CYC - 1;

    ////////////////////////////////////////////////////////////////////////
    // slow clock pins: three flops, a change counts once stages 2 and 3
    // agree; stage 1 feeds stage 2 only
    assign pin_chg = ~(pin_s2 ^ pin_s3) & (pin_s3 ^ pin_lvl);

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1   <= 3'h0;
            pin_s2   <= 3'h0;
            pin_s3   <= 3'h0;
            pin_lvl  <= 3'h0;
            pin_rise <= 3'h0;
        end
        else
        begin
            pin_s1   <= {ring_clk, pm_clk, rtc_clk};
            pin_s2   <= pin_s1;
            pin_s3   <= pin_s2;
            pin_lvl  <= pin_lvl ^ pin_chg;
            pin_rise <= pin_chg & pin_s3;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // scaled system clock: one enable pulse every WDG_SYS_DIV cycles
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sys_div  <= 5'h00;
            sys_tick <= 1'b0;
        end
        else
        begin
            sys_tick <= (sys_div == SYS_LAST[4:0]);
            if (sys_div == SYS_LAST[4:0])
                sys_div <= 5'h00;
            else
                sys_div <= sys_div + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // count clock choice for each main watchdog
    always @*
    begin
        case (ctrl_a[`WDG_SEL_MSB:`WDG_SEL_LSB])
            `WDG_SEL_RTC: tick_a = pin_rise[0];
            `WDG_SEL_PM:  tick_a = pin_rise[1];
            default:      tick_a = sys_tick;
        endcase
        case (ctrl_b[`WDG_SEL_MSB:`WDG_SEL_LSB])
            `WDG_SEL_RTC: tick_b = pin_rise[0];
            `WDG_SEL_PM:  tick_b = pin_rise[1];
            default:      tick_b = sys_tick;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // the three watchdogs
    wdg_counter #(
        .WIDTH    (32)
    ) u_main_watchdog_a (
        .clk      (ref_clk),
        .rst_n    (rst_n),
        .run      (ctrl_a[`WDG_EN_BIT]),
        .tick     (tick_a),
        .kick     (kick_a),
        .win_en   (ctrl_a[`WDG_WIN_BIT]),
        .presc    (ctrl_a[`WDG_PRE_MSB:`WDG_PRE_LSB]),
        .timeout  (tmo_a),
        .win_open (win_a),
        .count    (count_a),
        .expire   (exp_a)
    );

    wdg_counter #(
        .WIDTH    (32)
    ) u_main_watchdog_b (
        .clk      (ref_clk),
        .rst_n    (rst_n),
        .run      (ctrl_b[`WDG_EN_BIT]),
        .tick     (tick_b),
        .kick     (kick_b),
        .win_en   (ctrl_b[`WDG_WIN_BIT]),
        .presc    (ctrl_b[`WDG_PRE_MSB:`WDG_PRE_LSB]),
        .timeout  (tmo_b),
        .win_open (win_b),
        .count    (count_b),
        .expire   (exp_b)
    );

    // ring oscillator only, no prescaler and no window
    wdg_counter #(
        .WIDTH    (16)
    ) u_recovery_watchdog (
        .clk      (ref_clk),
        .rst_n    (rst_n),
        .run      (ctrl_r),
        .tick     (pin_rise[2]),
        .kick     (kick_r),
        .win_en   (1'b0),
        .presc    (8'h00),
        .timeout  (tmo_r),
        .win_open (16'h0000),
        .count    (count_r),
        .expire   (exp_r)
    );

    assign any_exp = exp_a | exp_b | exp_r;
    // register writes are dropped while the system reset is out
    assign bus_wr  = reg_wr & ~sys_reset;
    // a service write must carry the key, so stray writes do not feed it
    assign key_ok  = (reg_wdata[7:0] == `WDG_KICK_KEY);

    ////////////////////////////////////////////////////////////////////////
    // configuration registers; an expiry returns them to reset values as
    // the system reset would, while the cause flags survive
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_a <= `WDG_CTRL_RST;
            ctrl_b <= `WDG_CTRL_RST;
            ctrl_r <= 1'b0;
            tmo_a  <= `WDG_TMO_RST;
            tmo_b  <= `WDG_TMO_RST;
            win_a  <= `WDG_WIN_RST;
            win_b  <= `WDG_WIN_RST;
            tmo_r  <= `WDG_TMO_R_RST;
        end
        else if (any_exp)
        begin
            ctrl_a <= `WDG_CTRL_RST;
            ctrl_b <= `WDG_CTRL_RST;
            ctrl_r <= 1'b0;
            tmo_a  <= `WDG_TMO_RST;
            tmo_b  <= `WDG_TMO_RST;
            win_a  <= `WDG_WIN_RST;
            win_b  <= `WDG_WIN_RST;
            tmo_r  <= `WDG_TMO_R_RST;
        end
        else if (bus_wr)
        begin
            case (reg_addr)
                `WDG_CTRL_A:    ctrl_a <= reg_wdata[15:0];
                `WDG_TIMEOUT_A: tmo_a  <= reg_wdata;
                `WDG_WINDOW_A:  win_a  <= reg_wdata;
                `WDG_CTRL_B:    ctrl_b <= reg_wdata[15:0];
                `WDG_TIMEOUT_B: tmo_b  <= reg_wdata;
                `WDG_WINDOW_B:  win_b  <= reg_wdata;
                `WDG_CTRL_R:    ctrl_r <= reg_wdata[`WDG_EN_BIT];
                `WDG_TIMEOUT_R: tmo_r  <= reg_wdata[15:0];
                default:        ctrl_r <= ctrl_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // service pulses, one cycle after the keyed write
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            kick_a <= 1'b0;
            kick_b <= 1'b0;
            kick_r <= 1'b0;
        end
        else
        begin
            kick_a <= bus_wr & key_ok & (reg_addr == `WDG_KICK_A);
            kick_b <= bus_wr & key_ok & (reg_addr == `WDG_KICK_B);
            kick_r <= bus_wr & key_ok & (reg_addr == `WDG_KICK_R);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // system reset pulse, WDG_RST_CYC cycles from the expiry
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_cnt   <= 4'h0;
            sys_reset <= 1'b0;
        end
        else if (any_exp)
        begin
            rst_cnt   <= RST_LOAD[3:0];
            sys_reset <= 1'b1;
        end
        else if (rst_cnt != 4'h0)
            rst_cnt <= rst_cnt - 4'h1;
        else
            sys_reset <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // cause flags: set by expiry, cleared by writing one; set wins
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            reset_cause <= 3'h0;
        else
        begin
            reset_cause[`WDG_CAUSE_A] <= exp_a |
                (reset_cause[`WDG_CAUSE_A] &
                 ~(bus_wr & (reg_addr == `WDG_CAUSE) &
                   reg_wdata[`WDG_CAUSE_A]));
            reset_cause[`WDG_CAUSE_B] <= exp_b |
                (reset_cause[`WDG_CAUSE_B] &
                 ~(bus_wr & (reg_addr == `WDG_CAUSE) &
                   reg_wdata[`WDG_CAUSE_B]));
            reset_cause[`WDG_CAUSE_R] <= exp_r |
                (reset_cause[`WDG_CAUSE_R] &
                 ~(bus_wr & (reg_addr == `WDG_CAUSE) &
                   reg_wdata[`WDG_CAUSE_R]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data: valid only in the cycle after the strobe, else zero;
    // unmapped offsets and kick registers read zero
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 32'h00000000;
        else if (!reg_rd)
            reg_rdata <= 32'h00000000;
        else
        begin
            case (reg_addr)
                `WDG_CTRL_A:    reg_rdata <= {16'h0000, ctrl_a};
                `WDG_TIMEOUT_A: reg_rdata <= tmo_a;
                `WDG_WINDOW_A:  reg_rdata <= win_a;
                `WDG_CTRL_B:    reg_rdata <= {16'h0000, ctrl_b};
                `WDG_TIMEOUT_B: reg_rdata <= tmo_b;
                `WDG_WINDOW_B:  reg_rdata <= win_b;
                `WDG_CTRL_R:    reg_rdata <= {31'h00000000, ctrl_r};
                `WDG_TIMEOUT_R: reg_rdata <= {16'h0000, tmo_r};
                `WDG_CAUSE:     reg_rdata <= {29'h00000000, reset_cause};
                `WDG_COUNT_A:   reg_rdata <= count_a;
                `WDG_COUNT_B:   reg_rdata <= count_b;
                `WDG_COUNT_R:   reg_rdata <= {16'h0000, count_r};
                default:        reg_rdata <= 32'h00000000;
            endcase
        end
    end

endmodule // wdg_top

`default_nettype wire

// [verification/wdg_top_props.sv]
// port assertions for the watchdog subsystem
`timescale 1ns/1ps
`default_nettype none
`include "wdg_map.vh"

module wdg_top_props (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        rtc_clk,
    input wire logic        pm_clk,
    input wire logic        ring_clk,
    input wire logic        sys_reset,
    input wire logic [2:0]  reset_cause
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // cycles the reset request has stood; saturates so a stuck request
    // cannot wrap back onto the expected length
    logic [4:0] rst_run;

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_run <= 5'h00;
        else if (!sys_reset)
            rst_run <= 5'h00;
        else if (rst_run != 5'h1f)
            rst_run <= rst_run + 5'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // a flag may only appear together with the reset request it explains
    property flag_rise(int i);
        $rose(reset_cause[i]) |-> sys_reset;
    endproperty

    // flags survive everything except their own write-one-to-clear
    property flag_keep(int i);
        reset_cause[i] && !(reg_wr && reg_addr == `WDG_CAUSE && reg_wdata[i])
            |=> reset_cause[i];
    endproperty

    ////////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
        else $error("read data without a read");
    rdata_unmap_a: assert property (
        reg_rd && reg_addr > `WDG_COUNT_R |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    narrow_regs_a: assert property (
        reg_rd && (reg_addr == `WDG_COUNT_R || reg_addr == `WDG_TIMEOUT_R)
            |=> reg_rdata[31:16] == 16'h0)
        else $error("recovery register wider than 16 bits");
    cause_read_a: assert property (
        reg_rd && reg_addr == `WDG_CAUSE ##1 $stable(reset_cause)
            |-> reg_rdata == {29'h0, reset_cause})
        else $error("cause register differs from flags");
    reset_len_a: assert property (
        $fell(sys_reset) |-> rst_run == 5'(`WDG_RST_CYC))
        else $error("reset pulse length wrong");
    reset_max_a: assert property (
        rst_run <= 5'(`WDG_RST_CYC))
        else $error("reset pulse too long");
    reset_cause_a: assert property (
        $rose(sys_reset) |-> reset_cause != 3'h0)
        else $error("reset without any cause flag");
    flag_a_rise_a: assert property (flag_rise(0))
        else $error("flag a set without reset");
    flag_b_rise_a: assert property (flag_rise(1))
        else $error("flag b set without reset");
    flag_r_rise_a: assert property (flag_rise(2))
        else $error("recovery flag set without reset");
    flag_a_keep_a: assert property (flag_keep(0))
        else $error("flag a lost");
    flag_b_keep_a: assert property (flag_keep(1))
        else $error("flag b lost");
    flag_r_keep_a: assert property (flag_keep(2))
        else $error("recovery flag lost");
    flag_a_clear_a: assert property (
        reg_wr && !sys_reset && reg_addr == `WDG_CAUSE && reg_wdata[0]
            |=> !reset_cause[0] || $rose(sys_reset))
        else $error("flag a not cleared");

    cover property ($rose(reset_cause[0]));
    cover property ($rose(reset_cause[1]));
    cover property ($rose(reset_cause[2]));
endmodule // wdg_top_props

bind wdg_top wdg_top_props u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rtc_clk(rtc_clk), .pm_clk(pm_clk),
    .ring_clk(ring_clk), .sys_reset(sys_reset), .reset_cause(reset_cause));

`default_nettype wire

// [verification/windowed_and_recovery_watchdogs_test.sv]
// self-checking testbench for the watchdog subsystem
`timescale 1ns/1ps
`default_nettype none
`include "wdg_map.vh"

module windowed_and_recovery_watchdogs_test;
    logic        ref_clk, rst_n, reg_wr, reg_rd, rtc_clk, pm_clk, ring_clk;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    wire  [31:0] reg_rdata;
    wire         sys_reset;
    wire  [2:0]  reset_cause;
    int          n_errors, check_count, n, i;
    // per pass: count clock, prescale and cycles per counter step
    logic [1:0]  sel [4] = '{`WDG_SEL_SYS, `WDG_SEL_RTC, `WDG_SEL_PM,
                             `WDG_SEL_SYS};
    logic [7:0]  pre [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
    int          per [4] = '{`WDG_SYS_DIV, 10, 20, 2 * `WDG_SYS_DIV};

    wdg_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rtc_clk(rtc_clk), .pm_clk(pm_clk),
        .ring_clk(ring_clk), .sys_reset(sys_reset),
        .reset_cause(reset_cause));

    ////////////////////////////////////////////////////////////////////////
    // reference 10 MHz, rtc 1 MHz, power clock 500 kHz, ring 8 kHz
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial
    begin
        rtc_clk = 1'b0;
        forever #500 rtc_clk = ~rtc_clk;
    end
    initial
    begin
        pm_clk = 1'b0;
        forever #1000 pm_clk = ~pm_clk;
    end
    initial
    begin
        ring_clk = 1'b0;
        forever #62500 ring_clk = ~ring_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: %s got %h want %h", $time, what, got,
                     exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so look there
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp, what);
    endtask

    // bounded wait for the reset request; a miss ends the run
    task automatic wait_reset(input int bound, output int cnt);
        cnt = 0;
        while (sys_reset !== 1'b1 && cnt < bound)
        begin
            @(posedge ref_clk);
            #1 cnt++;
        end
        if (sys_reset !== 1'b1)
        begin
            n_errors++;
            $display("Error at %0t: no watchdog reset", $time);
            conclude();
        end
    endtask

    // writes are ignored during the pulse, so let it end first
    task automatic recover(input logic [2:0] exp, input logic [7:0] ctl);
        int k;
        chk({29'h0, reset_cause}, {29'h0, exp}, "cause flags");
        for (k = 0; k < 20 && sys_reset !== 1'b0; k++)
        begin
            @(posedge ref_clk);
            #1;
        end
        chk(k, `WDG_RST_CYC, "reset pulse length");
        rd(ctl, 32'h0, "ctrl after expiry");
        rd(`WDG_CAUSE, {29'h0, exp}, "cause register");
        wr(`WDG_CAUSE, 32'h7);
        rd(`WDG_CAUSE, 32'h0, "cause after clear");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        n_errors++;
        $display("Error at %0t: run limit reached", $time);
        conclude();
    end

    initial
    begin
        rst_n     = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        // reset values, a kick register and an unmapped place
        rd(`WDG_CTRL_A, 32'h0, "ctrl a");
        rd(`WDG_TIMEOUT_B, `WDG_TMO_RST, "timeout b");
        rd(`WDG_WINDOW_B, `WDG_WIN_RST, "window b");
        rd(`WDG_TIMEOUT_R, {16'h0, `WDG_TMO_R_RST}, "timeout r");
        rd(`WDG_KICK_A, 32'h0, "kick a");
        rd(8'h3c, 32'h0, "unmapped");
        rd(`WDG_CAUSE, 32'h0, "cause");
        // a left alone expires after timeout+1 steps on every count clock
        for (i = 0; i < 4; i++)
        begin
            wr(`WDG_TIMEOUT_A, 32'h3);
            wr(`WDG_CTRL_A, {16'h0, pre[i], 4'h0, sel[i], 2'b01});
            wait_reset(400, n);
            chk({31'h0, n >= 3 * per[i] && n <= 5 * per[i] + 12}, 32'h1,
                "expiry time");
            recover(3'h1, `WDG_CTRL_A);
        end
        // b serviced inside its window keeps the system alive
        wr(`WDG_TIMEOUT_B, 32'h3);
        wr(`WDG_WINDOW_B, 32'h2);
        wr(`WDG_CTRL_B, 32'h3);
        for (i = 0; i < 4; i++)
        begin
            repeat (40) @(posedge ref_clk);
            wr(`WDG_KICK_B, {24'h0, `WDG_KICK_KEY});
        end
        @(posedge ref_clk);
        rd(`WDG_COUNT_B, 32'h0, "count b after kick");
        chk({29'h0, reset_cause}, 32'h0, "no cause while serviced");
        // a kick before the window opens is a violation
        wr(`WDG_KICK_B, {24'h0, `WDG_KICK_KEY});
        wait_reset(10, n);
        recover(3'h2, `WDG_CTRL_B);
        // recovery watchdog runs on the ring oscillator alone
        wr(`WDG_TIMEOUT_R, 32'h1);
        wr(`WDG_CTRL_R, 32'h1);
        // serviced once after its first step, so the deadline restarts
        repeat (600) @(posedge ref_clk);
        wr(`WDG_KICK_R, {24'h0, `WDG_KICK_KEY});
        rd(`WDG_COUNT_R, 32'h0, "count r after kick");
        wait_reset(4000, n);
        chk({31'h0, n >= 1250 && n <= 2520}, 32'h1, "recovery time");
        recover(3'h4, `WDG_CTRL_R);
        conclude();
    end
endmodule // windowed_and_recovery_watchdogs_test

`default_nettype wire
